// ---- src/ubm_multiplier.sv ----
/*
  byte multiply execution unit of the cpu core.
  assumes the sequencer holds operands valid in the cycle the request is taken (start) and
  writes back the results to acc, aux register and flags on o_done.
*/
// Function
// - unsigned 8x8 operands, full 16-bit product
// - product low byte goes to accumulator
// - product high byte replaces auxiliary register
// - overflow set iff high byte nonzero
// - carry always cleared
`timescale 1ns/1ps
module ubm_multiplier
  import ubm_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_resetn,
  input  wire logic            i_byte_multiply_op,
  input  wire ubm_operand_type i_opnd,
  output logic                 o_busy,
  output logic                 o_done,
  output ubm_result_type       o_res
);
  // ------------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------------
  typedef enum logic {UBM_IDLE, UBM_RUN} ubm_state_type;

  // state decode shared by the sequencer, the busy flag and the checks
  function automatic logic ubm_in_run(input ubm_state_type st);
    return (st == UBM_RUN);
  endfunction : ubm_in_run

  ubm_state_type  state_q;
  ubm_state_type  state_d;
  logic [1:0]     cnt_q;
  logic [1:0]     cnt_d;
  logic           done_q;
  logic           done_d;
  ubm_result_type res_q;
  ubm_result_type res_d;
  logic [15:0]    prod;
  wire            start   = (state_q == UBM_IDLE) && i_byte_multiply_op;
  wire            last    = ubm_in_run(state_q) && (cnt_q == UBM_CNT_LAST);

  // a request while busy is ignored; the sequencer never overlaps ops
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      UBM_IDLE: begin
        cnt_d = UBM_CNT_RST;
        if (i_byte_multiply_op) begin
          state_d = UBM_RUN;
        end
      end
      UBM_RUN: begin
        cnt_d = 2'(cnt_q + 2'h1);
        if (last) begin
          state_d = UBM_IDLE;
        end
      end
      default: begin
        state_d = UBM_IDLE;
        cnt_d   = UBM_CNT_RST;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------------
  // product sampled at start so operand changes later cannot leak in
  ubm_product_reg u_prod (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_load   (start),
    .i_opnd   (i_opnd),
    .o_prod   (prod)
  );

  wire [7:0] prod_lo = prod[7:0];
  wire [7:0] prod_hi = prod[15:8];

  always_comb begin
    res_d = res_q;
    if (last) begin
      res_d.acc = prod_lo;
      res_d.aux = prod_hi;
      res_d.ov  = (prod_hi != UBM_BYTE_RST);
      res_d.cy  = 1'b0;
    end
  end
  assign done_d = last;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= UBM_IDLE;
      cnt_q   <= UBM_CNT_RST;
      done_q  <= 1'b0;
      res_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
      res_q   <= res_d;
    end
  end

  // busy registered: high the cycle after start, low after the last
  logic busy_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= ubm_in_run(state_d);
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_res  = res_q;

  // ------------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------------
  // counts running cycles so the four-cycle span is checked without long repetitions;
  // read by the assertions only, nothing in the datapath depends on it
  logic [3:0]     span_q;
  logic [3:0]     span_d;
  wire            running = ubm_in_run(state_q);

  assign span_d = running ? 4'(span_q + 4'h1) : 4'h0;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      span_q <= '0;
    end else begin
      span_q <= span_d;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  AST_LO_BYTE: assert property (
    start |-> ##5 (o_res.acc == 8'($past(i_opnd.acc, 5) * $past(i_opnd.aux, 5))))
    else $error("acc not low product byte");
  AST_HI_BYTE: assert property (
    start |-> ##5 (o_res.aux == 8'((16'($past(i_opnd.acc, 5)) *
                                    16'($past(i_opnd.aux, 5))) >> 8)))
    else $error("aux not high product byte");
  AST_FULL_PROD: assert property (
    start |-> ##1 (prod == 16'($past(i_opnd.acc)) * 16'($past(i_opnd.aux))))
    else $error("product wrong");
  AST_OV: assert property (
    o_done |-> (o_res.ov == (o_res.aux != 8'h00)))
    else $error("overflow flag wrong");
  AST_CY: assert property (
    o_done |-> !o_res.cy)
    else $error("carry not cleared");
  AST_DONE_TIME: assert property (
    start |=> !o_done [*4] ##1 o_done)
    else $error("done not after four cycles");
  AST_DONE_PULSE: assert property (
    o_done |=> !o_done)
    else $error("done longer than one cycle");
  AST_RES_STABLE: assert property (
    !o_done && !$past(last) |-> $stable(o_res))
    else $error("results changed outside completion");
  AST_BUSY_SPAN: assert property (
    start |=> o_busy [*4] ##1 !o_busy)
    else $error("busy span wrong");

  AST_OV_LIMIT: assert property (
    start |-> ##5 (o_res.ov == ((16'($past(i_opnd.acc, 5)) * 16'($past(i_opnd.aux, 5)))
                                > {8'h00, UBM_BYTE_MAX})))
    else $error("overflow does not follow the one-byte limit");

  AST_CY_HELD: assert property (
    !o_res.cy)
    else $error("carry seen set");

  AST_SPAN: assert property (
    o_done |-> (span_q == 4'(UBM_MUL_CYCLES)))
    else $error("operation did not run four cycles");

  AST_SPAN_BOUND: assert property (
    (span_q <= 4'(UBM_MUL_CYCLES)))
    else $error("operation ran longer than four cycles");

  AST_DONE_IDLE: assert property (
    o_done |-> (!o_busy && !running))
    else $error("done while still running");

  AST_PROD_HELD: assert property (
    running |=> $stable(prod))
    else $error("product changed while running");

  AST_RUN_HOLDS: assert property (
    running && !last |=> running)
    else $error("operation cut short");

  AST_CNT_RESTART: assert property (
    start |=> (cnt_q == UBM_CNT_RST))
    else $error("cycle count not restarted");

  AST_NO_OVERLAP: assert property (
    start |=> !start [*4])
    else $error("request taken while running");

  // ------------------------------------------------------------------
  // cover points
  // ------------------------------------------------------------------
  COV_OV_SET:   cover property (o_done && o_res.ov);
  COV_OV_CLR:   cover property (o_done && !o_res.ov);
  COV_MAX:      cover property (o_done && o_res.aux == UBM_BYTE_MAX - 8'h01);
  COV_BACK2BACK: cover property (o_done && start);
  COV_REQ_BUSY: cover property (running && i_byte_multiply_op);
endmodule : ubm_multiplier

// ---- src/ubm_pkg.sv ----
/*
  package for the unsigned byte multiplier: widths, cycle counts, carriers.
  assumes a single core clock; nothing here is clocked.
*/
package ubm_pkg;
  localparam int          UBM_BYTE_W      = 8;
  localparam int          UBM_PROD_W      = 16;
  localparam int          UBM_MUL_CYCLES  = 4;
  localparam logic [1:0]  UBM_CNT_RST     = 2'h0;
  localparam logic [1:0]  UBM_CNT_LAST    = 2'h3;
  localparam logic [7:0]  UBM_BYTE_RST    = 8'h00;
  localparam logic [7:0]  UBM_BYTE_MAX    = 8'hFF;
  localparam logic [15:0] UBM_PROD_RST    = 16'h0000;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] aux;
  } ubm_operand_type;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] aux;
    logic       ov;
    logic       cy;
  } ubm_result_type;
endpackage : ubm_pkg

// ---- src/ubm_product_reg.sv ----
/*
  registered 8x8 unsigned product stage.
  assumes operands are stable in the cycle i_load is high.
*/
`timescale 1ns/1ps
module ubm_product_reg
  import ubm_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_resetn,
  input  wire logic            i_load,
  input  wire ubm_operand_type i_opnd,
  output logic [15:0]          o_prod
);
  logic [15:0] prod_d;
  logic [15:0] prod_q;

  // full-width product, no truncation
  assign prod_d = UBM_PROD_W'(i_opnd.acc) * UBM_PROD_W'(i_opnd.aux);
  assign o_prod = prod_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prod_q <= UBM_PROD_RST;
    end else if (i_load) begin
      prod_q <= prod_d;
    end
  end
endmodule : ubm_product_reg

// ---- tb/tb_unsigned_byte_multiplier.sv ----
/*
  self-checking bench for the byte multiply unit.
  assumes ubm_pkg and ubm_multiplier are compiled first.
*/
`timescale 1ns/1ps
module tb_unsigned_byte_multiplier;
  import ubm_pkg::*;
  logic            i_clk = 1'b0;
  logic            i_resetn = 1'b0;
  logic            i_byte_multiply_op = 1'b0;
  ubm_operand_type i_opnd = '0;
  logic            o_busy;
  logic            o_done;
  ubm_result_type  o_res;
  ubm_result_type  exp_q[$];
  int              start_q[$];
  int              cyc = 0;
  int              mismatches = 0;
  int              cmp_count = 0;
  int              busy_cnt = 0;
  int              seed = 32'h9f8b_64c0;
  localparam logic [15:0] TBL [8] = '{16'h0000, 16'hFFFF, 16'h50A0, 16'h01FF,
                                      16'hFF01, 16'h1010, 16'h0100, 16'h8002};

  always #2.5 i_clk = ~i_clk;

  ubm_multiplier dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_opnd(i_opnd),
    .i_byte_multiply_op(i_byte_multiply_op), .o_busy(o_busy), .o_done(o_done), .o_res(o_res));

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  task automatic chk_res(input string nm, input ubm_result_type e, input ubm_result_type g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk_res

  task automatic chk_int(input string nm, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      mismatches++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk_int

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // outputs are read before this edge updates them and the start stamp is taken just
  // after its edge, so the stamp difference counts the running cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      mismatches++;
      tally_and_finish();
    end
    if (o_busy === 1'b1)
      busy_cnt++;
    if (o_done === 1'b1) begin
      if (exp_q.size() == 0)
        chk_int("extra_done", 0, 1);
      else begin
        chk_res("result", exp_q.pop_front(), o_res);
        chk_int("latency", UBM_MUL_CYCLES, cyc - start_q.pop_front());
        chk_int("busy_span", UBM_MUL_CYCLES, busy_cnt);
      end
      busy_cnt = 0;
    end
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  // operands are inverted mid-run: a unit that resamples them gets caught
  task automatic mul_op(input logic [7:0] a, input logic [7:0] b, input bit hold);
    logic [15:0] p;
    p = {8'h00, a} * {8'h00, b};
    i_opnd = {a, b};
    i_byte_multiply_op = 1'b1;
    @(posedge i_clk);
    #1;
    exp_q.push_back({p[7:0], p[15:8], p[15:8] != 8'h00, 1'b0});
    start_q.push_back(cyc);
    i_opnd = ~{a, b};
    i_byte_multiply_op = hold;
    repeat (3) @(posedge i_clk);
    #1;
    i_byte_multiply_op = 1'b0;
    for (int k = 0; k < 8 && o_done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
  endtask : mul_op

  initial begin
    repeat (10) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    foreach (TBL[i]) mul_op(TBL[i][15:8], TBL[i][7:0], i[0]);
    repeat (20) mul_op(8'($random(seed)), 8'($random(seed)), 1'b0);
    repeat (8) @(posedge i_clk);
    chk_int("pending", 0, exp_q.size());
    tally_and_finish();
  end
endmodule : tb_unsigned_byte_multiplier
